// *** core/period_timer_cfg.svh ***
// Constants of the period timer mode control.
// Overview of operation
// - Mode 00000: count while enable set, hold otherwise.
// - Modes 00001/00010: count while enable and gate level.
// - Modes 00011-00101: edge resets count, enable stops.
// - Modes 00110/00111: held reset at given signal level.
// - Mode 01000: one-shot started by enable alone.
// - Modes 01001-01011: one-shot started by chosen edge.
// - Modes 01100/01101: edge starts, later edges reset count.
// - Modes 01110/01111: edge start, opposite level holds reset.
// - One-shot match: clear enable, stop at zero.
// - Monostable 10001-10011: edge start, stop keeps enable.
// - Modes 10110/10111: level start, opposite level resets.
// - Edge modes need fresh edge after enable set.
// - Flag raised when postscale count reaches selection.
// - Interrupt request only when period irq enabled.
// - Count per tick; after match return zero, postscale.
`ifndef PERIOD_TIMER_CFG_SVH
`define PERIOD_TIMER_CFG_SVH
`define PT_COUNT_W 8
`define PT_POST_W 4
`define PT_COUNT_RST 8'h00
`define PT_PERIOD_RST 8'hFF
`define PT_POST_RST 4'h0
`endif

// *** core/period_timer_pkg.sv ***
// Types shared by the period timer mode control.
package period_timer_pkg;
  // Decoded behaviour of one mode code.
  typedef struct packed {
    logic valid;
    logic one_shot;
    logic mono;
    logic sw_start;
    logic start_rise;
    logic start_fall;
    logic start_high;
    logic start_low;
    logic gate_high;
    logic gate_low;
    logic rst_rise;
    logic rst_fall;
    logic rst_high;
    logic rst_low;
  } mode_dec_t;
  // Edge and level view of the external reset signal.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ers_view_t;
endpackage : period_timer_pkg

// *** core/ers_sync.sv ***
// Synchroniser and edge detector for the external reset signal.
`timescale 1ns/1ps
`default_nettype none
module ers_sync (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Raw signal and its view.
  input wire logic sig_in,
  output var period_timer_pkg::ers_view_t view
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // Two stages, then a third copy for edges so the first stage feeds only the second.
  always_comb begin
    nxt_meta = sig_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
    view.level = sync_ff;
    view.rise = sync_ff & ~last_ff;
    view.fall = ~sync_ff & last_ff;
  end

  // Register stage.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end
endmodule : ers_sync
`default_nettype wire

// *** core/period_timer_mode_control.sv ***
// Mode control, counter and postscaler of the 8-bit period timer.
`timescale 1ns/1ps
`default_nettype none
`include "period_timer_cfg.svh"
module period_timer_mode_control #(
  parameter int COUNT_W = `PT_COUNT_W,
  parameter int POST_W = `PT_POST_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Timer tick from the prescaler, one cycle wide.
  input wire logic timer_tick,
  // Software control.
  input wire logic [4:0] mode_select,
  input wire logic enable_set,
  input wire logic enable_clear,
  input wire logic [COUNT_W-1:0] period_register,
  input wire logic period_load,
  input wire logic [POST_W-1:0] postscale_select,
  input wire logic period_irq_enable,
  input wire logic irq_flag_clear,
  // External reset signal from another peripheral.
  input wire logic external_reset_signal,
  // Status and outputs.
  output logic enable_ff,
  output logic running_ff,
  output logic [COUNT_W-1:0] count_value_ff,
  output logic postscaled_pulse_ff,
  output logic period_irq_flag_ff,
  output logic irq_request_ff
);
  // The sized reset constants and increments are written for these widths only.
  if (COUNT_W != 8 || POST_W != 4) begin : g_width_check
    $error("period_timer_mode_control supports only 8-bit count and 4-bit postscale");
  end

  // Decode a mode code into its start, reset and stop behaviour.
  function automatic period_timer_pkg::mode_dec_t decode(input logic [4:0] m);
    period_timer_pkg::mode_dec_t d;
    d = '0;
    d.valid = 1'b1;
    case (m)
      5'h00: d.sw_start = 1'b1;
      5'h01: begin d.sw_start = 1'b1; d.gate_high = 1'b1; end
      5'h02: begin d.sw_start = 1'b1; d.gate_low = 1'b1; end
      5'h03: begin d.sw_start = 1'b1; d.rst_rise = 1'b1; d.rst_fall = 1'b1; end
      5'h04: begin d.sw_start = 1'b1; d.rst_rise = 1'b1; end
      5'h05: begin d.sw_start = 1'b1; d.rst_fall = 1'b1; end
      5'h06: begin d.sw_start = 1'b1; d.rst_low = 1'b1; end
      5'h07: begin d.sw_start = 1'b1; d.rst_high = 1'b1; end
      5'h08: begin d.one_shot = 1'b1; d.sw_start = 1'b1; end
      5'h09: begin d.one_shot = 1'b1; d.start_rise = 1'b1; end
      5'h0A: begin d.one_shot = 1'b1; d.start_fall = 1'b1; end
      5'h0B: begin d.one_shot = 1'b1; d.start_rise = 1'b1; d.start_fall = 1'b1; end
      5'h0C: begin d.one_shot = 1'b1; d.start_rise = 1'b1; d.rst_rise = 1'b1; end
      5'h0D: begin d.one_shot = 1'b1; d.start_fall = 1'b1; d.rst_fall = 1'b1; end
      5'h0E: begin d.one_shot = 1'b1; d.start_rise = 1'b1; d.rst_low = 1'b1; end
      5'h0F: begin d.one_shot = 1'b1; d.start_fall = 1'b1; d.rst_high = 1'b1; end
      5'h11: begin d.mono = 1'b1; d.start_rise = 1'b1; end
      5'h12: begin d.mono = 1'b1; d.start_fall = 1'b1; end
      5'h13: begin d.mono = 1'b1; d.start_rise = 1'b1; d.start_fall = 1'b1; end
      5'h16: begin d.one_shot = 1'b1; d.start_high = 1'b1; d.rst_low = 1'b1; end
      5'h17: begin d.one_shot = 1'b1; d.start_low = 1'b1; d.rst_high = 1'b1; end
      default: d = '0;
    endcase
    return d;
  endfunction : decode

  // Synchronised view of the external signal.
  period_timer_pkg::ers_view_t ers;
  ers_sync u_ers_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig_in(external_reset_signal),
    .view(ers)
  );

  period_timer_pkg::mode_dec_t dec;
  logic [4:0] mode_ff;
  logic [COUNT_W-1:0] period_buf_ff;
  logic [POST_W-1:0] post_cnt_ff;
  logic rise_seen_ff;
  logic fall_seen_ff;
  logic nxt_enable;
  logic nxt_running;
  logic [COUNT_W-1:0] nxt_count;
  logic [COUNT_W-1:0] nxt_period_buf;
  logic [POST_W-1:0] nxt_post_cnt;
  logic nxt_pulse;
  logic nxt_flag;
  logic nxt_irq;
  logic [4:0] nxt_mode;
  logic nxt_rise_seen;
  logic nxt_fall_seen;
  logic start_evt;
  logic hw_reset;
  logic gate_ok;
  logic match;
  logic ext_rst_evt;
  logic mode_change;

  // Next-state logic of the whole timer.
  always_comb begin
    dec = decode(mode_ff);
    nxt_mode = mode_select;
    mode_change = (mode_select != mode_ff);
    nxt_enable = enable_ff;
    nxt_running = running_ff;
    nxt_count = count_value_ff;
    nxt_period_buf = period_buf_ff;
    nxt_post_cnt = post_cnt_ff;
    nxt_pulse = 1'b0;
    nxt_rise_seen = rise_seen_ff;
    nxt_fall_seen = fall_seen_ff;
    // Edges are latched between ticks so a short pulse is not lost to a slow tick.
    if (ers.rise) nxt_rise_seen = 1'b1;
    if (ers.fall) nxt_fall_seen = 1'b1;
    if (enable_set) nxt_enable = 1'b1;
    else if (enable_clear) nxt_enable = 1'b0;
    match = (count_value_ff == period_buf_ff);
    gate_ok = (!dec.gate_high || ers.level) && (!dec.gate_low || !ers.level);
    hw_reset = (dec.rst_high && ers.level) || (dec.rst_low && !ers.level);
    // Edge starts need an edge seen while enabled; edges before enable are dropped.
    start_evt = (dec.start_rise && rise_seen_ff) || (dec.start_fall && fall_seen_ff)
      || (dec.start_high && ers.level) || (dec.start_low && !ers.level)
      || dec.sw_start;
    ext_rst_evt = running_ff && ((dec.rst_rise && rise_seen_ff) ||
      (dec.rst_fall && fall_seen_ff));
    if (!enable_ff) begin
      nxt_running = 1'b0;
      nxt_rise_seen = 1'b0;
      nxt_fall_seen = 1'b0;
    end else if (timer_tick) begin
      // An edge arriving on the tick cycle is kept for the next tick, else it is lost.
      nxt_rise_seen = ers.rise;
      nxt_fall_seen = ers.fall;
      if (!dec.valid) begin
        nxt_running = 1'b0;
      end else if (hw_reset || ext_rst_evt) begin
        nxt_count = `PT_COUNT_RST;
        nxt_post_cnt = `PT_POST_RST;
        nxt_period_buf = period_register;
        if (hw_reset) nxt_running = 1'b0;
      end else if (!running_ff) begin
        if (start_evt) begin
          nxt_running = 1'b1;
          nxt_post_cnt = `PT_POST_RST;
        end
      end else if (gate_ok) begin
        if (match) begin
          nxt_count = `PT_COUNT_RST;
          nxt_period_buf = period_register;
          if (post_cnt_ff == postscale_select) begin
            nxt_post_cnt = `PT_POST_RST;
            nxt_pulse = 1'b1;
          end else begin
            nxt_post_cnt = post_cnt_ff + 4'h1;
          end
          if (dec.one_shot) begin
            nxt_enable = 1'b0;
            nxt_running = 1'b0;
          end
          if (dec.mono) nxt_running = 1'b0;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end
    end
    // A control write reloads the period buffer and clears the postscaler.
    if (period_load || enable_set || enable_clear || mode_change) begin
      nxt_period_buf = period_register;
      nxt_post_cnt = `PT_POST_RST;
    end
    // Set wins over software clear.
    nxt_flag = nxt_pulse || (period_irq_flag_ff && !irq_flag_clear);
    nxt_irq = nxt_flag && period_irq_enable;
  end

  // Register stage.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_ff <= 5'h00;
      enable_ff <= 1'b0;
      running_ff <= 1'b0;
      count_value_ff <= `PT_COUNT_RST;
      period_buf_ff <= `PT_PERIOD_RST;
      post_cnt_ff <= `PT_POST_RST;
      rise_seen_ff <= 1'b0;
      fall_seen_ff <= 1'b0;
      postscaled_pulse_ff <= 1'b0;
      period_irq_flag_ff <= 1'b0;
      irq_request_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      enable_ff <= nxt_enable;
      running_ff <= nxt_running;
      count_value_ff <= nxt_count;
      period_buf_ff <= nxt_period_buf;
      post_cnt_ff <= nxt_post_cnt;
      rise_seen_ff <= nxt_rise_seen;
      fall_seen_ff <= nxt_fall_seen;
      postscaled_pulse_ff <= nxt_pulse;
      period_irq_flag_ff <= nxt_flag;
      irq_request_ff <= nxt_irq;
    end
  end
endmodule : period_timer_mode_control
`default_nettype wire

// *** bench/period_timer_props.sv ***
// Assertion checker for the period timer mode control ports.
`timescale 1ns/1ps
`default_nettype none
module period_timer_props #(
  parameter int COUNT_W = 8,
  parameter int POST_W = 4
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs seen.
  input wire logic timer_tick,
  input wire logic [4:0] mode_select,
  input wire logic period_irq_enable,
  input wire logic irq_flag_clear,
  // Outputs watched.
  input wire logic enable_ff,
  input wire logic [COUNT_W-1:0] count_value_ff,
  input wire logic postscaled_pulse_ff,
  input wire logic period_irq_flag_ff,
  input wire logic irq_request_ff
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_hold_no_tick: assert property (!timer_tick |=> $stable(count_value_ff))
    else $error("count moved without a tick");
  a_step_or_wrap: assert property (
    timer_tick |=> count_value_ff == $past(count_value_ff) + 1'b1
    || count_value_ff == 8'h00 || $stable(count_value_ff))
    else $error("count jumped");
  a_pulse_wraps: assert property (
    postscaled_pulse_ff |-> count_value_ff == 8'h00 && $past(timer_tick))
    else $error("pulse without rollover");
  a_pulse_flag: assert property (postscaled_pulse_ff |-> period_irq_flag_ff)
    else $error("pulse left flag low");
  a_flag_sticky: assert property (
    period_irq_flag_ff && !irq_flag_clear |=> period_irq_flag_ff)
    else $error("flag dropped");
  // A clear in the same cycle removes the flag, so the request may not follow then.
  a_irq_fwd: assert property (
    period_irq_flag_ff && !irq_flag_clear && period_irq_enable |=> irq_request_ff)
    else $error("request missing");
  a_irq_gated: assert property (!period_irq_enable |=> !irq_request_ff)
    else $error("request while masked");
  a_idle_no_count: assert property (
    !enable_ff |=> $stable(count_value_ff) || count_value_ff == 8'h00)
    else $error("count moved while disabled");
  a_reserved_stop: assert property (
    (mode_select[4:3] == 2'h3) [*3] |=> $stable(count_value_ff))
    else $error("count moved in reserved mode");
  // Main scenarios reached.
  c_pulse: cover property (postscaled_pulse_ff);
  c_shot_end: cover property ($fell(enable_ff) && count_value_ff == 8'h00);
  c_request: cover property (irq_request_ff);
endmodule : period_timer_props
bind period_timer_mode_control period_timer_props #(.COUNT_W(COUNT_W), .POST_W(POST_W)) props_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .timer_tick(timer_tick),
  .mode_select(mode_select),
  .period_irq_enable(period_irq_enable),
  .irq_flag_clear(irq_flag_clear),
  .enable_ff(enable_ff),
  .count_value_ff(count_value_ff),
  .postscaled_pulse_ff(postscaled_pulse_ff),
  .period_irq_flag_ff(period_irq_flag_ff),
  .irq_request_ff(irq_request_ff)
);
`default_nettype wire

// *** bench/ers_source.sv ***
// Model of the peripheral that drives the external reset signal.
`timescale 1ns/1ps
`default_nettype none
module ers_source (
  // Clock.
  input wire logic mclk,
  // Requested level and driven signal.
  input wire logic level_req,
  output logic ers_out
);
  // Level moves only at an edge and then holds, so the bench sets spacing.
  always_ff @(posedge mclk) begin
    ers_out <= level_req;
  end
endmodule : ers_source
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the period timer mode control.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, sys_rst = 1'b1, timer_tick = 1'b0, enable_set = 1'b0, enable_clear = 1'b0;
  logic period_load = 1'b0, period_irq_enable = 1'b0, irq_flag_clear = 1'b0, lvl = 1'b0;
  logic [4:0] mode_select = 5'h00;
  logic [7:0] period_register = 8'h02, top_cnt, n_pulse, count, hold;
  logic [3:0] postscale_select = 4'h0;
  logic ers, enable_ff, running_ff, pulse, flag, irq;
  int miscompares = 0, n_compared = 0;
  // Free-running clock.
  always #2.5 mclk = ~mclk;
  ers_source src (.mclk(mclk), .level_req(lvl), .ers_out(ers));
  period_timer_mode_control dut (.mclk(mclk), .sys_rst(sys_rst), .timer_tick(timer_tick),
    .mode_select(mode_select), .enable_set(enable_set), .enable_clear(enable_clear),
    .period_register(period_register), .period_load(period_load),
    .postscale_select(postscale_select), .period_irq_enable(period_irq_enable),
    .irq_flag_clear(irq_flag_clear), .external_reset_signal(ers), .enable_ff(enable_ff),
    .running_ff(running_ff), .count_value_ff(count), .postscaled_pulse_ff(pulse),
    .period_irq_flag_ff(flag), .irq_request_ff(irq));
  task chk(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pls(ref logic s);
    s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask : pls
  // Ticks on n cycles in a row; the trailing idle cycle keeps drives apart.
  task run(input int n);
    top_cnt = 8'h00;
    n_pulse = 8'h00;
    timer_tick = 1'b1;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (count > top_cnt) top_cnt = count;
      n_pulse += pulse;
    end
    timer_tick = 1'b0;
    @(posedge mclk);
    #1;
  endtask : run
  task walk_free;
    period_irq_enable = 1'b1;
    pls(period_load);
    pls(enable_set);
    run(1);
    run(1);
    chk("count", count, 8'h01);
    chk("running", running_ff, 8'h01);
    run(1);
    chk("count", count, 8'h02);
    run(1);
    chk("count", count, 8'h00);
    chk("pulse", n_pulse, 8'h01);
    chk("request", irq, 8'h01);
    period_irq_enable = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("request", irq, 8'h00);
    chk("flag", flag, 8'h01);
    pls(irq_flag_clear);
    chk("flag", flag, 8'h00);
  endtask : walk_free
  task one_shot;
    pls(enable_clear);
    mode_select = 5'h08;
    run(4);
    chk("peak", top_cnt, 8'h00);
    pls(enable_set);
    run(8);
    chk("peak", top_cnt, 8'h02);
    chk("enable", enable_ff, 8'h00);
    chk("count", count, 8'h00);
    chk("running", running_ff, 8'h00);
  endtask : one_shot
  task mono;
    mode_select = 5'h11;
    pls(enable_set);
    run(8);
    chk("peak", top_cnt, 8'h00);
    lvl = 1'b1;
    run(12);
    chk("peak", top_cnt, 8'h02);
    chk("enable", enable_ff, 8'h01);
    chk("count", count, 8'h00);
    chk("running", running_ff, 8'h00);
  endtask : mono
  // The low level must pass the synchroniser before the gate mode is chosen.
  task gate_and_reserved;
    lvl = 1'b0;
    run(4);
    mode_select = 5'h01;
    run(8);
    chk("peak", top_cnt, 8'h00);
    chk("running", running_ff, 8'h01);
    lvl = 1'b1;
    run(8);
    chk("peak", top_cnt, 8'h02);
    mode_select = 5'h18;
    @(posedge mclk);
    #1 hold = count;
    run(8);
    chk("count", count, hold);
    chk("count", count, 8'h02);
    chk("running", running_ff, 8'h00);
  endtask : gate_and_reserved
  // High-level reset mode: held at zero while the signal is high, runs once it is low.
  task hw_level_reset;
    mode_select = 5'h07;
    run(4);
    chk("count", count, 8'h00);
    chk("running", running_ff, 8'h00);
    lvl = 1'b0;
    run(8);
    chk("peak", top_cnt, 8'h02);
    chk("running", running_ff, 8'h01);
  endtask : hw_level_reset
  task tally_and_finish;
    $display("miscompares %0d, n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    walk_free();
    one_shot();
    mono();
    gate_and_reserved();
    hw_level_reset();
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 100 cycles the scenarios need.
  initial begin
    #3000;
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
